//--- core/tswk_top.sv
// Mode decode, measurement sequencing and wake/reset pulse generation.
// Assumes pins arrive asynchronously and the serial clock may stand still.
`timescale 1ns/1ns
`default_nettype none

module tswk_top #(
    parameter int unsigned LFO_DIV      = tswk_pkg::LFO_DIV_CYC,
    parameter int unsigned WAKE_STAGES  = tswk_pkg::WAKE_STAGES,
    parameter int unsigned CHAIN_STAGES = tswk_pkg::CHAIN_STAGES,
    parameter int unsigned HOLD_CYC     = tswk_pkg::HOLD_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 serial_clk_i,
    input  wire logic                 mode_select_low_i,
    input  wire logic                 mode_select_high_i,
    input  wire logic                 trim_detect_i,
    input  wire logic                 serial_threshold_in_i,
    input  wire logic                 comparator_i,
    output var  tswk_pkg::tswk_ctrl_t ctrl_o,
    output var  logic [7:0]           threshold_latch_o,
    output var  logic                 wake_out_o,
    output var  logic                 reset_n_o,
    output var  logic                 pull_down_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks.
    if (LFO_DIV < 2 || WAKE_STAGES < 1 || WAKE_STAGES >= CHAIN_STAGES || HOLD_CYC < 1 || HOLD_CYC > 999) begin : g_bad
        $error("tswk_top: unsupported divider or hold parameters");
    end

    localparam int unsigned DIV_W  = $clog2(LFO_DIV);
    localparam int unsigned HOLD_W = $clog2(HOLD_CYC + 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(LFO_DIV - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for pins and the serial latch toggle.
    localparam int unsigned SYNC_W = 5;

    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic              thr_tgl_seen;
    logic [7:0]        ser_thr;
    logic              ser_tgl;

    wire [SYNC_W-1:0] raw_in = {ser_tgl, comparator_i, trim_detect_i, mode_select_high_i, mode_select_low_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire sel_low  = sync_b[0];
    wire sel_high = sync_b[1];
    wire trim_s   = sync_b[2];
    wire comp_s   = sync_b[3];
    wire tgl_s    = sync_b[4];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode; a high-voltage detect overrides the select pins.
    tswk_pkg::tswk_mode_t mode;
    tswk_pkg::tswk_mode_t next_mode;

    always_comb begin
        case ({trim_s, sel_high, sel_low})
            3'b000:  next_mode = tswk_pkg::TSWK_STANDBY;
            3'b001:  next_mode = tswk_pkg::TSWK_PRESS;
            3'b010:  next_mode = tswk_pkg::TSWK_TEMP;
            3'b011:  next_mode = tswk_pkg::TSWK_READ;
            default: next_mode = tswk_pkg::TSWK_TRIM;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= tswk_pkg::TSWK_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    wire standby = (mode == tswk_pkg::TSWK_STANDBY);
    wire in_read = (mode == tswk_pkg::TSWK_READ);
    wire [tswk_pkg::NUM_CH-1:0] chan_sel = {mode == tswk_pkg::TSWK_TEMP, mode == tswk_pkg::TSWK_PRESS};

    ////////////////////////////////////////////////////////////////////////
    // Per-channel sequencing: power first, then mux; mux opens before power off.
    wire  [tswk_pkg::NUM_CH-1:0] chan_power;
    wire  [tswk_pkg::NUM_CH-1:0] chan_mux;
    logic                        comp_en;
    logic                        trim_on;
    logic                        meas_on;

    for (genvar c = 0; c < tswk_pkg::NUM_CH; c++) begin : g_chan
        logic              pwr;
        logic              mx;
        logic [HOLD_W-1:0] hold_cnt;
        wire               hold_done = (hold_cnt == HOLD_LAST);

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                pwr      <= 1'b0;
                mx       <= 1'b0;
                hold_cnt <= '0;
            end else if (chan_sel[c]) begin
                pwr      <= 1'b1;
                mx       <= pwr;
                hold_cnt <= '0;
            end else begin
                mx <= 1'b0;
                if (pwr && !mx) begin
                    hold_cnt <= hold_cnt + 1'b1;
                    if (hold_done) begin
                        pwr <= 1'b0;
                    end
                end
            end
        end

        assign chan_power[c] = pwr;
        assign chan_mux[c]   = mx;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_en        <= 1'b0;
            trim_on        <= 1'b0;
            meas_on        <= 1'b0;
            pull_down_en_o <= 1'b1;
        end else begin
            comp_en        <= in_read;
            trim_on        <= (mode == tswk_pkg::TSWK_TRIM);
            meas_on        <= (next_mode == tswk_pkg::TSWK_PRESS) || (next_mode == tswk_pkg::TSWK_TEMP);
            pull_down_en_o <= 1'b1;
        end
    end

    assign ctrl_o = '{power: chan_power, mux: chan_mux, comp_en: comp_en, trim: trim_on};

    ////////////////////////////////////////////////////////////////////////
    // Serial path and the threshold latch crossing.
    tswk_serial u_serial (
        .serial_clk_i          (serial_clk_i),
        .rst_i                 (rst_i),
        .serial_threshold_in_i (serial_threshold_in_i),
        .meas_i                (meas_on),
        .thr_o                 (ser_thr),
        .thr_tgl_o             (ser_tgl)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            thr_tgl_seen      <= 1'b0;
            threshold_latch_o <= tswk_pkg::THR_RST;
        end else begin
            thr_tgl_seen <= tgl_s;
            if (tgl_s != thr_tgl_seen) begin
                threshold_latch_o <= ser_thr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator tick and divider chain, running in every mode.
    logic [DIV_W-1:0]        lfo_cnt;
    logic [CHAIN_STAGES-1:0] chain;
    logic                    wake_pulse;
    logic [1:0]              rst_left;

    wire lfo_tick   = (lfo_cnt == DIV_LAST);
    wire wake_ovf   = lfo_tick && (&chain[WAKE_STAGES-1:0]);
    wire chain_ovf  = lfo_tick && (&chain);
    wire rst_active = (rst_left != 2'b00);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lfo_cnt <= '0;
            chain   <= '0;
        end else begin
            lfo_cnt <= lfo_tick ? '0 : lfo_cnt + 1'b1;
            if (lfo_tick) begin
                chain <= chain + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_pulse <= 1'b0;
            rst_left   <= 2'b00;
        end else begin
            if (wake_ovf) begin
                wake_pulse <= 1'b1;
            end else if (lfo_tick) begin
                wake_pulse <= 1'b0;
            end
            if (chain_ovf) begin
                rst_left <= 2'(tswk_pkg::RST_TICKS);
            end else if (lfo_tick && rst_active) begin
                rst_left <= rst_left - 2'b01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins.
    wire next_wake = standby ? !wake_pulse : (comp_s && !rst_active);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_out_o <= 1'b1;
            reset_n_o  <= 1'b1;
        end else begin
            wake_out_o <= next_wake;
            reset_n_o  <= !rst_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    localparam int HOLD_MAX = int'(HOLD_CYC) + 1;
    logic [31:0]    rst_low_cnt;
    logic [DIV_W:0] wake_hi_cnt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_low_cnt <= '0;
            wake_hi_cnt <= '0;
        end else begin
            rst_low_cnt <= reset_n_o ? 32'h0 : rst_low_cnt + 32'h1;
            wake_hi_cnt <= wake_pulse ? wake_hi_cnt + 1'b1 : '0;
        end
    end

    property p_mode_read;
        @(posedge clk_i) disable iff (rst_i)
        (sel_low && sel_high && !trim_s) |=> (mode == tswk_pkg::TSWK_READ) ##1 ctrl_o.comp_en;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("output read not decoded");

    property p_press_on;
        @(posedge clk_i) disable iff (rst_i)
        chan_sel[0] ##1 chan_sel[0] |=> ctrl_o.power[0] && ctrl_o.mux[0];
    endproperty
    a_press_on: assert property (p_press_on) else $error("pressure channel not powered and routed");

    property p_press_off;
        @(posedge clk_i) disable iff (rst_i)
        $fell(ctrl_o.mux[0]) && !chan_sel[0] |-> ctrl_o.power[0] ##[1:HOLD_MAX] (!ctrl_o.power[0] || chan_sel[0]);
    endproperty
    a_press_off: assert property (p_press_off) else $error("pressure power dropped before mux");

    property p_temp_off;
        @(posedge clk_i) disable iff (rst_i)
        $fell(ctrl_o.power[1]) |-> !ctrl_o.mux[1] && !$past(ctrl_o.mux[1]);
    endproperty
    a_temp_off: assert property (p_temp_off) else $error("temperature power dropped with mux closed");

    property p_temp_on;
        @(posedge clk_i) disable iff (rst_i)
        $rose(ctrl_o.mux[1]) |-> ctrl_o.power[1] && $past(chan_sel[1]);
    endproperty
    a_temp_on: assert property (p_temp_on) else $error("temperature mux closed without power");

    property p_wake_standby;
        @(posedge clk_i) disable iff (rst_i)
        standby ##1 standby |-> (wake_out_o == !$past(wake_pulse));
    endproperty
    a_wake_standby: assert property (p_wake_standby) else $error("standby wake output wrong");

    property p_wake_ovf;
        @(posedge clk_i) disable iff (rst_i)
        wake_ovf |=> wake_pulse [*2];
    endproperty
    a_wake_ovf: assert property (p_wake_ovf) else $error("wake pulse missing on overflow");

    property p_rst_width;
        @(posedge clk_i) disable iff (rst_i)
        $rose(reset_n_o) |-> (rst_low_cnt == 32'(tswk_pkg::RST_TICKS * LFO_DIV));
    endproperty
    a_rst_width: assert property (p_rst_width) else $error("reset pulse width wrong");

    property p_rst_start;
        @(posedge clk_i) disable iff (rst_i)
        chain_ovf |=> ##1 !reset_n_o;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("reset pulse missing on full overflow");

    property p_rst_wake;
        @(posedge clk_i) disable iff (rst_i)
        $fell(reset_n_o) |-> !wake_out_o;
    endproperty
    a_rst_wake: assert property (p_rst_wake) else $error("wake output not pulsed with reset");

    property p_read_comp;
        @(posedge clk_i) disable iff (rst_i)
        in_read && !rst_active |=> (wake_out_o == $past(comp_s));
    endproperty
    a_read_comp: assert property (p_read_comp) else $error("wake output does not follow comparator");

    property p_wake_one_tick;
        @(posedge clk_i) disable iff (rst_i)
        $fell(wake_pulse) |-> (wake_hi_cnt == (DIV_W + 1)'(LFO_DIV));
    endproperty
    a_wake_one_tick: assert property (p_wake_one_tick) else $error("wake pulse not one oscillator cycle");

endmodule

`default_nettype wire

//--- common/tswk_pkg.sv
// Package of constants and types for the tire sensor mode and wake logic.
// Assumes a 125 MHz system clock and a serial clock supplied from outside.
package tswk_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock rates and the low frequency oscillator.
    localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
    localparam int unsigned LFO_FREQ_HZ   = 5400;
    localparam int unsigned LFO_DIV_CYC   = CLK_FREQ_HZ / LFO_FREQ_HZ;

    ////////////////////////////////////////////////////////////////////////
    // Divider chain and pulse widths, in oscillator cycles.
    localparam int unsigned WAKE_STAGES   = 14;
    localparam int unsigned CHAIN_STAGES  = 24;
    localparam int unsigned WAKE_TICKS    = 1;
    localparam int unsigned RST_TICKS     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Delay from multiplexer release to power down of a measuring circuit.
    localparam int unsigned HOLD_NS       = 1000;
    localparam int unsigned HOLD_CYC      = (HOLD_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////
    // Serial threshold path.
    localparam int unsigned THR_W         = 8;
    localparam logic [7:0]  THR_RST       = 8'h00;
    localparam logic [3:0]  SER_LAST      = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Channel indices of the measuring circuits.
    localparam int unsigned CH_PRESS      = 0;
    localparam int unsigned CH_TEMP       = 1;
    localparam int unsigned NUM_CH        = 2;

    typedef enum logic [2:0] {
        TSWK_STANDBY,
        TSWK_PRESS,
        TSWK_TEMP,
        TSWK_READ,
        TSWK_TRIM
    } tswk_mode_t;

    typedef struct packed {
        logic [NUM_CH-1:0] power;
        logic [NUM_CH-1:0] mux;
        logic              comp_en;
        logic              trim;
    } tswk_ctrl_t;

endpackage

//--- core/tswk_serial.sv
// Serial threshold shift path, clocked by the serial clock from the controller.
// Assumes the measurement flag comes from a flop of the system clock domain.
`timescale 1ns/1ns
`default_nettype none

module tswk_serial (
    input  wire logic       serial_clk_i,
    input  wire logic       rst_i,
    input  wire logic       serial_threshold_in_i,
    input  wire logic       meas_i,
    output var  logic [7:0] thr_o,
    output var  logic       thr_tgl_o
);

    logic [7:0] shift;
    logic [3:0] count;
    wire        count_clr = rst_i | meas_i;
    wire        last_bit  = (count == tswk_pkg::SER_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Shift on the rising edge, most significant bit first.
    always_ff @(posedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift <= tswk_pkg::THR_RST;
        end else begin
            shift <= {shift[6:0], serial_threshold_in_i};
        end
    end

    // Bit counter, cleared while a measurement mode is selected.
    always_ff @(posedge serial_clk_i or posedge count_clr) begin
        if (count_clr) begin
            count <= 4'h0;
        end else begin
            count <= last_bit ? 4'h1 : count + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch on the falling edge of the eighth clock and flag it by a toggle.
    always_ff @(negedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            thr_o     <= tswk_pkg::THR_RST;
            thr_tgl_o <= 1'b0;
        end else if (last_bit) begin
            thr_o     <= shift;
            thr_tgl_o <= ~thr_tgl_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_latch_eighth;
        @(negedge serial_clk_i) disable iff (rst_i)
        last_bit |=> (thr_o == $past(shift)) && (thr_tgl_o != $past(thr_tgl_o));
    endproperty
    a_latch_eighth: assert property (p_latch_eighth) else $error("threshold not latched on eighth clock");

    property p_count_clear;
        @(posedge serial_clk_i) disable iff (rst_i)
        meas_i |-> (count == 4'h0);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("bit counter not cleared in measure mode");

    property p_msb_first;
        @(posedge serial_clk_i) disable iff (rst_i || meas_i)
        1'b1 |=> (shift[0] == $past(serial_threshold_in_i)) && (shift[7:1] == $past(shift[6:0]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("serial bit not shifted in msb first");

endmodule

`default_nettype wire

//--- dv/tswk_mcu.sv
// Controller model: drives the mode pins and the serial threshold link.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
`default_nettype none

module tswk_mcu (
    input  wire logic clk_i,
    output var  logic mode_select_low_o,
    output var  logic mode_select_high_o,
    output var  logic serial_clk_o,
    output var  logic serial_threshold_in_o
);
    initial begin
        mode_select_low_o     = 1'b0;
        mode_select_high_o    = 1'b0;
        serial_clk_o          = 1'b0;
        serial_threshold_in_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode pins change just after a falling edge of the system clock.
    task automatic set_mode(input logic hi, input logic lo);
        @(negedge clk_i);
        mode_select_high_o = hi;
        mode_select_low_o  = lo;
    endtask

    // Shifts n bits msb first; between frames the clock stands low.
    task automatic shift(input int n, input logic [31:0] bits);
        #5;
        for (int i = n - 1; i >= 0; i--) begin
            serial_threshold_in_o = bits[i];
            #16 serial_clk_o = 1'b1;
            #16 serial_clk_o = 1'b0;
        end
        // Released data falls to its pull-down level.
        #8 serial_threshold_in_o = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/tswk_top_test.sv
// Self-checking bench for the mode, serial threshold and divider logic.
// Assumes shortened divider and hold parameters for a short run.
`timescale 1ns/1ns
`default_nettype none

module tswk_top_test;
    localparam int unsigned DIV  = 4;
    localparam int unsigned WST  = 4;
    localparam int unsigned CST  = 6;
    localparam int unsigned HOLD = 4;
    localparam logic [5:0]  EXP_CTRL [5] = '{6'h00, 6'h14, 6'h28, 6'h02, 6'h01};

    logic                 clk_i;
    logic                 rst_i;
    logic                 serial_clk;
    logic                 mode_select_low;
    logic                 mode_select_high;
    logic                 serial_threshold_in;
    logic                 trim_detect;
    logic                 comparator;
    tswk_pkg::tswk_ctrl_t ctrl_o;
    logic [7:0]           threshold_latch_o;
    logic                 wake_out_o;
    logic                 reset_n_o;
    logic                 pull_down_en_o;
    logic [31:0]          rng;
    logic [31:0]          r;
    int                   mismatches;
    int                   checks;
    int                   model_sr;
    int                   model_cnt;
    int                   model_thr;
    int                   since_rst;
    int                   n;
    int                   bad;

    tswk_mcu u_mcu (.clk_i(clk_i), .mode_select_low_o(mode_select_low), .mode_select_high_o(mode_select_high),
                    .serial_clk_o(serial_clk), .serial_threshold_in_o(serial_threshold_in));

    tswk_top #(.LFO_DIV(DIV), .WAKE_STAGES(WST), .CHAIN_STAGES(CST), .HOLD_CYC(HOLD)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk), .mode_select_low_i(mode_select_low),
        .mode_select_high_i(mode_select_high), .trim_detect_i(trim_detect),
        .serial_threshold_in_i(serial_threshold_in), .comparator_i(comparator), .ctrl_o(ctrl_o),
        .threshold_latch_o(threshold_latch_o), .wake_out_o(wake_out_o), .reset_n_o(reset_n_o),
        .pull_down_en_o(pull_down_en_o));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) since_rst <= (reset_n_o === 1'b1) ? since_rst + 1 : 0;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    task automatic set(input int m);
        u_mcu.set_mode(m == 2 || m == 3, m == 1 || m == 3);
        trim_detect = (m == 4);
        if (m == 1 || m == 2) model_cnt = 0;
    endtask

    task automatic watch(input int ch, input int k);
        repeat (k) begin
            @(negedge clk_i);
            if (ctrl_o.power[ch] === 1'b1 && ctrl_o.mux[ch] === 1'b0) n++;
            if (ctrl_o.power[ch] === 1'b0 && ctrl_o.mux[ch] === 1'b1) bad++;
        end
    endtask

    task automatic send(input int k, input logic [31:0] bits);
        u_mcu.shift(k, bits);
        for (int i = k - 1; i >= 0; i--) begin
            model_sr = ((model_sr << 1) | int'(bits[i])) & 255;
            model_cnt++;
            if (model_cnt == 8) begin
                model_thr = model_sr;
                model_cnt = 0;
            end
        end
        cyc(8);
        chk("threshold", model_thr, threshold_latch_o);
    endtask

    task automatic divs(input int m);
        int t;
        int tw;
        int tr;
        logic pw;
        logic pr;
        t = 0;
        tw = -1;
        tr = -1;
        set(m);
        comparator = 1'b1;
        cyc(8);
        pw = wake_out_o;
        pr = reset_n_o;
        repeat (700) begin
            @(negedge clk_i);
            t++;
            if (reset_n_o === 1'b0 && pr === 1'b1) begin
                chk("wake with reset", 0, wake_out_o);
                if (tr >= 0) chk("reset period", (1 << CST) * DIV, t - tr);
                tr = t;
            end
            if (reset_n_o === 1'b1 && pr === 1'b0 && tr >= 0) chk("reset width", 2 * DIV, t - tr);
            if (wake_out_o === 1'b0 && pw === 1'b1) begin
                if (tw >= 0) chk("wake period", (1 << (m == 0 ? WST : CST)) * DIV, t - tw);
                tw = t;
            end
            if (wake_out_o === 1'b1 && pw === 1'b0 && tw >= 0) chk("wake width", (m == 0 ? 1 : 2) * DIV, t - tw);
            pr = reset_n_o;
            pw = wake_out_o;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        rng = 32'hd801ba92;
        rst_i = 1'b1;
        trim_detect = 1'b0;
        comparator = 1'b0;
        mismatches = 0;
        checks = 0;
        model_sr = 0;
        model_cnt = 0;
        model_thr = 0;
        cyc(2);
        rst_i = 1'b0;
        cyc(1);
        chk("ctrl", 0, ctrl_o);
        chk("threshold", 0, threshold_latch_o);
        chk("wake", 1, wake_out_o);
        chk("reset", 1, reset_n_o);
        chk("pull down", 1, pull_down_en_o);
        $display("test reset done");
        for (int m = 0; m < 5; m++) begin
            set(m);
            cyc(16);
            chk("ctrl", EXP_CTRL[m], ctrl_o);
            for (int k = 0; k < 4 && m > 0 && m < 4; k++) begin
                r = xorshift();
                comparator = r[0];
                cyc(6);
                if (reset_n_o === 1'b1 && since_rst > 4) chk("wake", comparator, wake_out_o);
            end
        end
        $display("test modes done");
        for (int ch = 0; ch < 2; ch++) begin
            n = 0;
            bad = 0;
            set(ch + 1);
            watch(ch, 12);
            set(0);
            watch(ch, HOLD + 20);
            chk("hold cycles", HOLD + 1, n);
            chk("mux without power", 0, bad);
            chk("power off", 0, ctrl_o.power);
        end
        $display("test hold done");
        divs(0);
        divs(3);
        $display("test dividers done");
        set(0);
        cyc(16);
        repeat (3) send(8, xorshift());
        set(3);
        cyc(16);
        send(8, xorshift());
        send(5, xorshift());
        set(1);
        cyc(16);
        set(0);
        cyc(16);
        send(8, xorshift());
        send(16, xorshift());
        $display("test serial done");
        report_and_stop();
    end
endmodule
`default_nettype wire
